//--- verilog/umi_aux.sv
/*
 * auxiliary uart modes: multidrop address filtering, infrared coding, sleep with
 * wake-up, bus isolation and internal loopback.
 * assumes the receiver core hands over whole characters with parity, the baud
 * generator supplies a 16x tick, and register bits arrive as plain levels.
 */
`timescale 1ns/1ps
module umi_aux (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_sys_rst,
	// configuration levels
	input  wire logic                i_multidrop,
	input  wire logic                i_feat_unlock,
	input  wire logic                i_spec_char_en,
	input  wire logic [1:0]          i_word_len,
	input  wire logic [7:0]          i_station_addr,
	input  wire logic                i_irda_en,
	input  wire logic                i_irda11,
	input  wire logic                i_loopback,
	input  wire logic                i_sleep_en,
	input  wire logic                i_wake_int_en,
	input  wire logic                i_bus_isolate_pin,
	// host pulses
	input  wire logic                i_rx_en_set,
	input  wire logic                i_rx_en_clr,
	input  wire logic                i_thr_write,
	input  wire logic                i_isr_read,
	// core status
	input  wire logic                i_int_pending,
	input  wire logic                i_msr_delta_zero,
	input  wire logic                i_divisor_nz,
	input  wire logic                i_tx_fifo_empty,
	input  wire logic                i_rx_fifo_empty,
	input  wire logic                i_tick16,
	// received characters
	input  wire logic                i_rx_valid,
	input  wire umi_pkg::umi_char_t  i_rx_char,
	input  wire logic                i_rx_perr,
	// serial and modem side
	input  wire logic                i_tx_shift,
	input  wire logic                i_rts_core_n,
	input  wire logic                i_dtr_core_n,
	input  wire logic                i_rx_pin,
	input  wire umi_pkg::umi_modem_t i_modem_n,
	output logic                     o_tx_pin,
	output logic                     o_rts_n,
	output logic                     o_dtr_n,
	output logic                     o_rx_serial,
	output umi_pkg::umi_modem_t      o_modem_n,
	// to receive fifo
	output logic                     o_push,
	output umi_pkg::umi_char_t       o_push_char,
	output logic                     o_push_perr,
	output logic                     o_lsr_int,
	output logic                     o_rx_enabled,
	// power
	output logic                     o_asleep,
	output logic                     o_osc_run,
	output logic                     o_bus_isolated,
	output logic                     o_wake_int
);
	logic                md_normal;
	logic                md_auto;
	logic                addr_byte;
	logic                addr_match;
	logic                nxt_push;
	logic                nxt_perr;
	logic                nxt_int;
	logic                hw_rx_on;
	logic                hw_rx_off;
	logic                ir_tx;
	logic                ir_rx;
	logic                rx_idle;
	logic                can_sleep;
	logic                wake_line;
	logic                rx_prev_ff;
	umi_pkg::umi_modem_t modem_prev_ff;

	// ==========================================================
	// multidrop decode
	assign md_normal = i_multidrop && i_feat_unlock && !i_spec_char_en;
	assign md_auto   = i_multidrop && i_feat_unlock && i_spec_char_en;
	// forced zero parity makes the raw parity bit the address flag
	assign addr_byte = i_rx_char.par;
	// masked compare against the station address
	assign addr_match = ((i_rx_char.data ^ i_station_addr)
		& umi_pkg::umi_word_mask(i_word_len)) == 8'h00;

	// receive filter decision
	always_comb begin
		nxt_push  = 1'b0;
		nxt_perr  = 1'b0;
		nxt_int   = 1'b0;
		hw_rx_on  = 1'b0;
		hw_rx_off = 1'b0;
		if (!i_rx_valid) begin
			nxt_push = 1'b0;
		end else if (md_normal) begin
			// host decides on the address from the stored byte
			if (addr_byte) begin
				nxt_push = 1'b1;
				nxt_perr = 1'b1;
				nxt_int  = 1'b1;
			end else begin
				nxt_push = o_rx_enabled;
			end
		end else if (md_auto) begin
			if (addr_byte && addr_match) begin
				hw_rx_on = 1'b1;
				nxt_push = 1'b1;
				nxt_perr = i_rx_char.par;
				nxt_int  = 1'b1;
			end else if (addr_byte) begin
				hw_rx_off = 1'b1;
			end else begin
				nxt_push = o_rx_enabled;
			end
		end else begin
			nxt_push = 1'b1;
			nxt_perr = i_rx_perr;
			nxt_int  = i_rx_perr;
		end
	end

	// ==========================================================
	// receiver enable, hardware and host set win over clears
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_rx_enabled <= 1'b0;
		else if (hw_rx_on || i_rx_en_set)
			o_rx_enabled <= 1'b1;
		else if (hw_rx_off || i_rx_en_clr)
			o_rx_enabled <= 1'b0;
	end

	// fifo push and line status pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_push      <= 1'b0;
			o_push_char <= '0;
			o_push_perr <= 1'b0;
			o_lsr_int   <= 1'b0;
		end else begin
			o_push      <= nxt_push;
			o_push_char <= i_rx_char;
			o_push_perr <= nxt_perr;
			o_lsr_int   <= nxt_int;
		end
	end

	// ==========================================================
	// infrared coder
	umi_irda u_irda (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_tick    (i_tick16),
		.i_enable  (i_irda_en),
		.i_ir11    (i_irda11 && i_feat_unlock),
		.i_tx_bit  (i_tx_shift),
		.i_rx_pin  (i_rx_pin),
		.o_tx_ir   (ir_tx),
		.o_rx_bit  (ir_rx)
	);

	// ==========================================================
	// pin muxing and loopback
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_tx_pin    <= 1'b1;
			o_rts_n     <= 1'b1;
			o_dtr_n     <= 1'b1;
			o_rx_serial <= 1'b1;
			o_modem_n   <= umi_pkg::MODEM_IDLE;
		end else if (i_loopback) begin
			o_tx_pin    <= 1'b1;
			o_rts_n     <= 1'b1;
			o_dtr_n     <= 1'b1;
			o_rx_serial <= i_tx_shift;
			o_modem_n   <= umi_pkg::MODEM_IDLE;
		end else begin
			o_tx_pin    <= i_irda_en ? ir_tx : i_tx_shift;
			o_rts_n     <= i_rts_core_n;
			o_dtr_n     <= i_dtr_core_n;
			o_rx_serial <= i_irda_en ? ir_rx : i_rx_pin;
			o_modem_n   <= i_modem_n;
		end
	end

	// ==========================================================
	// sleep conditions and wake events
	assign rx_idle = i_irda_en ? !i_rx_pin : i_rx_pin;
	assign can_sleep = !i_int_pending && i_sleep_en && i_msr_delta_zero && rx_idle
		&& i_divisor_nz && i_tx_fifo_empty && i_rx_fifo_empty;

	// previous line and modem levels for edge detection
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_prev_ff    <= 1'b1;
			modem_prev_ff <= umi_pkg::MODEM_IDLE;
		end else begin
			rx_prev_ff    <= o_rx_serial;
			modem_prev_ff <= i_modem_n;
		end
	end

	// start edge or modem change; modem ignored in loopback
	assign wake_line = (rx_prev_ff && !o_rx_serial)
		|| (!i_loopback && (modem_prev_ff != i_modem_n));

	umi_sleep u_sleep (
		.i_clk         (i_clk),
		.i_sys_rst     (i_sys_rst),
		.i_can_sleep   (can_sleep),
		.i_sleep_en    (i_sleep_en),
		.i_isolate_pin (i_bus_isolate_pin),
		.i_wake_line   (wake_line),
		.i_wake_host   (i_thr_write),
		.i_wake_int_en (i_wake_int_en),
		.i_isr_read    (i_isr_read),
		.o_asleep      (o_asleep),
		.o_osc_run     (o_osc_run),
		.o_isolated    (o_bus_isolated),
		.o_wake_int    (o_wake_int)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_md_drop_data: assert property (
		i_rx_valid && md_normal && !o_rx_enabled && !addr_byte |=> !o_push)
		else $error("data kept with receiver off");
	a_md_addr_flag: assert property (
		i_rx_valid && md_normal && addr_byte |=> o_push && o_push_perr && o_lsr_int)
		else $error("address byte not flagged");
	a_md_enabled_data: assert property (
		i_rx_valid && md_normal && o_rx_enabled |=> o_push)
		else $error("enabled receiver dropped data");
	a_auto_match: assert property (
		i_rx_valid && md_auto && addr_byte && addr_match
		|=> o_rx_enabled && o_push && o_push_perr && o_lsr_int)
		else $error("matching address mishandled");
	a_auto_miss: assert property (
		i_rx_valid && md_auto && addr_byte && !addr_match && !i_rx_en_set
		|=> !o_rx_enabled && !o_push)
		else $error("mismatching address kept");
	a_loop_pins: assert property (
		i_loopback |=> o_tx_pin && o_rts_n && o_dtr_n && o_modem_n == umi_pkg::MODEM_IDLE)
		else $error("loopback pins not held");
	a_loop_route: assert property (i_loopback |=> o_rx_serial == $past(i_tx_shift))
		else $error("loopback path broken");
	a_sleep_entry: assert property ($rose(o_asleep) |-> $past(can_sleep))
		else $error("sleep entered without conditions");
	a_no_sleep_int: assert property (i_int_pending && !o_asleep |=> !o_asleep)
		else $error("slept with pending interrupt");
	a_auto_drop_data: assert property (
		i_rx_valid && md_auto && !o_rx_enabled && !addr_byte |=> !o_push)
		else $error("auto mode kept data with receiver off");
	a_plain_pass: assert property (
		i_rx_valid && !md_normal && !md_auto |=> o_push && o_push_perr == $past(i_rx_perr))
		else $error("byte not passed outside multidrop");
	a_ir_off_tx: assert property (
		!i_irda_en && !i_loopback |=> o_tx_pin == $past(i_tx_shift))
		else $error("plain transmit path broken");
	a_line_wake: assert property (
		o_asleep && wake_line |=> !o_asleep)
		else $error("line or modem event did not wake");
	a_loop_no_modem: assert property (
		i_loopback && o_asleep && i_sleep_en && !i_thr_write && !(rx_prev_ff && !o_rx_serial)
		|=> o_asleep)
		else $error("modem input woke device in loopback");

	// main scenarios reached
	c_line_wake: cover property (o_asleep && wake_line);
	c_auto_match: cover property (i_rx_valid && md_auto && addr_byte && addr_match);
	c_md_address: cover property (i_rx_valid && md_normal && addr_byte);
	c_loopback: cover property (i_loopback ##1 o_push);

endmodule : umi_aux

//--- verilog/umi_pkg.sv
/*
 * shared constants and types for the multidrop / infrared / sleep / loopback block.
 * assumes a 16x baud tick from the baud generator and 8-bit characters from the receiver.
 */
package umi_pkg;

	// ==========================================================
	// line control encodings
	localparam logic [2:0] PAR_FORCE0 = 3'h7;  // force parity zero
	localparam logic [1:0] WLEN_5     = 2'h0;
	localparam logic [1:0] WLEN_6     = 2'h1;
	localparam logic [1:0] WLEN_7     = 2'h2;
	localparam logic [7:0] MASK_5     = 8'h1F;
	localparam logic [7:0] MASK_6     = 8'h3F;
	localparam logic [7:0] MASK_7     = 8'h7F;
	localparam logic [7:0] MASK_8     = 8'hFF;

	// ==========================================================
	// infrared timing in 16x ticks
	localparam logic [3:0] TICK_LAST  = 4'hF;  // sixteen ticks per bit
	localparam logic [3:0] IR10_WIDTH = 4'h3;  // 3/16 bit
	localparam logic [3:0] IR11_WIDTH = 4'h4;  // 1/4 bit
	localparam logic [3:0] TICK_ZERO  = 4'h0;

	// ==========================================================
	// types
	typedef struct packed {
		logic [7:0] data;
		logic       par;  // received parity bit
	} umi_char_t;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic cd_n;
		logic ri_n;
	} umi_modem_t;

	localparam umi_modem_t MODEM_IDLE = 4'hF;

	// low-order bits that take part in a character compare
	function automatic logic [7:0] umi_word_mask(input logic [1:0] wlen);
		logic [7:0] m;
		m = MASK_8;
		case (wlen)
			WLEN_5:  m = MASK_5;
			WLEN_6:  m = MASK_6;
			WLEN_7:  m = MASK_7;
			default: m = MASK_8;
		endcase
		return m;
	endfunction : umi_word_mask

endpackage : umi_pkg

//--- verilog/umi_irda.sv
/*
 * infrared encoder and decoder.
 * assumes i_tick is a one-cycle 16x baud pulse and tx bits last sixteen ticks.
 */
`timescale 1ns/1ps
module umi_irda (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// control
	input  wire logic i_tick,
	input  wire logic i_enable,
	input  wire logic i_ir11,
	// data
	input  wire logic i_tx_bit,
	input  wire logic i_rx_pin,
	output logic      o_tx_ir,
	output logic      o_rx_bit
);
	logic [3:0] tx_cnt_ff;
	logic       tx_prev_ff;
	logic [3:0] rx_cnt_ff;
	logic       rx_low_ff;
	logic       rx_prev_ff;
	logic [3:0] width;

	// ==========================================================
	// encoder
	assign width = i_ir11 ? umi_pkg::IR11_WIDTH : umi_pkg::IR10_WIDTH;

	// bit phase counter, realigned on every tx bit change
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_cnt_ff  <= umi_pkg::TICK_ZERO;
			tx_prev_ff <= 1'b1;
		end else begin
			tx_prev_ff <= i_tx_bit;
			if (i_tx_bit != tx_prev_ff)
				tx_cnt_ff <= umi_pkg::TICK_ZERO;
			else if (i_tick)
				tx_cnt_ff <= tx_cnt_ff + 4'h1;
		end
	end

	// high pulse at the start of each zero bit; bit and phase both registered
	// so a count left from the previous bit cannot stretch the pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_tx_ir <= 1'b0;
		else
			o_tx_ir <= i_enable && !tx_prev_ff && (tx_cnt_ff < width);
	end

	// ==========================================================
	// decoder: a light pulse yields one zero bit
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_prev_ff <= 1'b0;  // idle dark
			rx_cnt_ff  <= umi_pkg::TICK_ZERO;
			rx_low_ff  <= 1'b0;
		end else begin
			rx_prev_ff <= i_rx_pin;
			if (i_enable && i_rx_pin && !rx_prev_ff) begin
				rx_low_ff <= 1'b1;
				rx_cnt_ff <= umi_pkg::TICK_ZERO;
			end else if (rx_low_ff && i_tick) begin
				rx_cnt_ff <= rx_cnt_ff + 4'h1;
				if (rx_cnt_ff == umi_pkg::TICK_LAST)
					rx_low_ff <= 1'b0;
			end
		end
	end

	// decoded stream idles at mark
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_rx_bit <= 1'b1;
		else
			o_rx_bit <= !rx_low_ff;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_ir_zero_only: assert property (o_tx_ir |-> !$past(i_tx_bit, 2))
		else $error("ir pulse sent for a one bit");
	a_ir_decode: assert property (i_enable && i_rx_pin && !rx_prev_ff |=> ##1 !o_rx_bit)
		else $error("light pulse not decoded");

endmodule : umi_irda

//--- verilog/umi_sleep.sv
/*
 * sleep state, oscillator gate, bus isolation and wake-up interrupt.
 * assumes i_clk keeps running so wake events are seen; o_osc_run gates the crystal.
 */
`timescale 1ns/1ps
module umi_sleep (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// entry conditions
	input  wire logic i_can_sleep,
	input  wire logic i_sleep_en,
	input  wire logic i_isolate_pin,
	// wake events
	input  wire logic i_wake_line,
	input  wire logic i_wake_host,
	// wake interrupt
	input  wire logic i_wake_int_en,
	input  wire logic i_isr_read,
	// status
	output logic      o_asleep,
	output logic      o_osc_run,
	output logic      o_isolated,
	output logic      o_wake_int
);
	typedef enum logic {UMI_AWAKE, UMI_ASLEEP} umi_sleep_t;
	umi_sleep_t state_ff;
	logic       wake;

	// bus writes cannot wake an isolated device
	assign wake = i_wake_line || (i_wake_host && !o_isolated);

	// ==========================================================
	// sleep state machine
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_ff <= UMI_AWAKE;
		end else begin
			case (state_ff)
				UMI_AWAKE:
					if (i_can_sleep && !wake)
						state_ff <= UMI_ASLEEP;
				UMI_ASLEEP:
					if (wake || !i_sleep_en)
						state_ff <= UMI_AWAKE;
				default: state_ff <= UMI_AWAKE;
			endcase
		end
	end

	// outputs follow the next state so they stay in step
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_asleep   <= 1'b0;
			o_osc_run  <= 1'b1;
			o_isolated <= 1'b0;
		end else begin
			o_asleep   <= (state_ff == UMI_AWAKE) ? (i_can_sleep && !wake)
				: !(wake || !i_sleep_en);
			o_osc_run  <= (state_ff == UMI_AWAKE) ? !(i_can_sleep && !wake)
				: (wake || !i_sleep_en);
			o_isolated <= i_isolate_pin && ((state_ff == UMI_AWAKE)
				? (i_can_sleep && !wake) : !(wake || !i_sleep_en));
		end
	end

	// sticky wake interrupt, set wins over the clearing read
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_wake_int <= 1'b0;
		else if (i_wake_int_en && state_ff == UMI_ASLEEP && wake)
			o_wake_int <= 1'b1;
		else if (i_isr_read)
			o_wake_int <= 1'b0;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_osc_stopped: assert property (o_asleep |-> !o_osc_run)
		else $error("oscillator runs in sleep");
	a_isolate_asleep: assert property (o_isolated |-> o_asleep && i_isolate_pin)
		else $error("bus isolated while awake");
	a_host_wake: assert property (o_asleep && i_wake_host && !o_isolated |=> !o_asleep)
		else $error("host write did not wake");
	a_iso_no_wake: assert property (o_isolated && i_sleep_en && !i_wake_line |=> o_asleep)
		else $error("isolated device woke on bus");
	c_sleep_wake: cover property (o_asleep ##[1:20] !o_asleep);

endmodule : umi_sleep

//--- tb/umi_tb_line.sv
/*
 * far-side model of the serial line: a remote transmitter or an infrared transceiver.
 * assumes requests come from the bench as one-cycle pulses on the block clock.
 */
`timescale 1ns/1ps
module umi_tb_line (
	// clock
	input  wire logic                i_clk,
	// requests from the bench
	input  wire logic                i_ir_mode,
	input  wire logic                i_start,
	input  wire umi_pkg::umi_modem_t i_modem,
	// line side
	output logic                     o_rx_pin,
	output umi_pkg::umi_modem_t      o_modem_n
);
	// ==========================================================
	// start bit or light pulse length in clocks
	int cnt = 0;

	// a wired start bit lasts one bit, a light pulse 3/16 of it
	always_ff @(posedge i_clk) begin
		if (i_start) begin
			cnt <= i_ir_mode ? 3 : 16;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end

	// idle mark when wired, dark when infrared
	assign o_rx_pin = (cnt > 0) ? i_ir_mode : !i_ir_mode;

	// modem lines change just after an edge
	always_ff @(posedge i_clk) begin
		o_modem_n <= i_modem;
	end
endmodule : umi_tb_line

//--- tb/tb_top.sv
/*
 * self-checking bench for the auxiliary uart modes.
 * assumes a free-running 10 MHz block clock and a 16x tick on every clock.
 */
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// stimulus
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic md = 1'b0, unl = 1'b0, spec = 1'b0, ire = 1'b0, ir11 = 1'b0, lb = 1'b0;
	logic sen = 1'b0, wie = 1'b0, iso = 1'b0, rv = 1'b0, rperr = 1'b0, txs = 1'b1;
	logic rtsc = 1'b1, dtrc = 1'b1, tick = 1'b1, st = 1'b0;
	logic [1:0] wl = 2'h3;
	logic [7:0] sta = 8'h00;
	logic [3:0] pls = 4'h0;
	logic [4:0] cnd = 5'h1F;
	logic [3:0] mdm = 4'hF;
	umi_pkg::umi_char_t rch = 9'h000;
	int errors = 0;
	int total_checks = 0;
	int k;
	logic o_tx_pin, o_rts_n, o_dtr_n, o_rx_serial, o_push, o_push_perr, o_lsr_int;
	logic o_rx_enabled, o_asleep, o_osc_run, o_bus_isolated, o_wake_int, rx_pin;
	umi_pkg::umi_modem_t o_modem_n, modem_n;
	umi_pkg::umi_char_t o_push_char;

	// clock
	initial begin
		forever #50 clk = ~clk;
	end

	umi_tb_line i_line (.i_clk(clk), .i_ir_mode(ire), .i_start(st), .i_modem(mdm),
		.o_rx_pin(rx_pin), .o_modem_n(modem_n));

	umi_aux i_dut (.i_clk(clk), .i_sys_rst(rst), .i_multidrop(md), .i_feat_unlock(unl),
		.i_spec_char_en(spec), .i_word_len(wl), .i_station_addr(sta), .i_irda_en(ire),
		.i_irda11(ir11), .i_loopback(lb), .i_sleep_en(sen), .i_wake_int_en(wie),
		.i_bus_isolate_pin(iso), .i_rx_en_set(pls[0]), .i_rx_en_clr(pls[1]),
		.i_thr_write(pls[2]), .i_isr_read(pls[3]), .i_int_pending(!cnd[0]),
		.i_msr_delta_zero(cnd[4]), .i_divisor_nz(cnd[3]), .i_tx_fifo_empty(cnd[2]),
		.i_rx_fifo_empty(cnd[1]), .i_tick16(tick), .i_rx_valid(rv), .i_rx_char(rch),
		.i_rx_perr(rperr), .i_tx_shift(txs), .i_rts_core_n(rtsc), .i_dtr_core_n(dtrc),
		.i_rx_pin(rx_pin), .i_modem_n(modem_n), .o_tx_pin(o_tx_pin), .o_rts_n(o_rts_n),
		.o_dtr_n(o_dtr_n), .o_rx_serial(o_rx_serial), .o_modem_n(o_modem_n),
		.o_push(o_push), .o_push_char(o_push_char), .o_push_perr(o_push_perr),
		.o_lsr_int(o_lsr_int), .o_rx_enabled(o_rx_enabled), .o_asleep(o_asleep),
		.o_osc_run(o_osc_run), .o_bus_isolated(o_bus_isolated), .o_wake_int(o_wake_int));

	// ==========================================================
	// tasks
	task automatic summarize;
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rst_dut;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
	endtask : rst_dut

	// host pulse: bit 0 set, 1 clear, 2 transmit write, 3 status read
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		pls <= m;
		@(posedge clk);
		pls <= 4'h0;
	endtask : pulse

	// one received character, then push, flags and enable state
	task automatic rx_byte(input logic [7:0] d, input logic p, input logic ep,
		input logic epe, input logic ei, input logic een);
		@(posedge clk);
		rv <= 1'b1;
		rch <= {d, p};
		@(posedge clk);
		rv <= 1'b0;
		@(negedge clk);
		chk(o_push, ep);
		chk(o_lsr_int, ei);
		if (ep) begin
			chk(o_push_char, {d, p});
			chk(o_push_perr, epe);
		end
		@(negedge clk);
		chk(o_rx_enabled, een);
	endtask : rx_byte

	task automatic wait_sl(input logic exp, input int lim);
		int n;
		n = 0;
		@(negedge clk);
		while (o_asleep !== exp && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(o_asleep, exp);
		if (o_asleep !== exp) summarize();
	endtask : wait_sl

	task automatic hold(input logic exp, input int n);
		repeat (n) begin
			@(negedge clk);
			chk(o_asleep, exp);
		end
	endtask : hold

	// ==========================================================
	// scenarios
	initial begin
		rst_dut();
		@(negedge clk);
		chk({o_tx_pin, o_rts_n, o_dtr_n, o_rx_serial, o_push, o_lsr_int, o_rx_enabled,
			o_asleep, o_osc_run}, 9'h1E1);
		chk({o_wake_int, o_bus_isolated, o_modem_n}, 9'h00F);
		// normal multidrop
		@(posedge clk);
		md <= 1'b1;
		unl <= 1'b1;
		rx_byte(8'h55, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_byte(8'h12, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		pulse(4'h1);
		rx_byte(8'h66, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		rx_byte(8'h13, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		pulse(4'h2);
		rx_byte(8'h67, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		unl <= 1'b0;
		rx_byte(8'h55, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		// automatic address detection, five then eight bit compare
		rst_dut();
		@(posedge clk);
		unl <= 1'b1;
		spec <= 1'b1;
		wl <= 2'h0;
		sta <= 8'hE5;
		rx_byte(8'h05, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_byte(8'h06, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_byte(8'h25, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		rx_byte(8'h77, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		rx_byte(8'h05, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		rx_byte(8'h07, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		wl <= 2'h3;
		rx_byte(8'h25, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_byte(8'hE5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		// loopback in and out
		@(posedge clk);
		md <= 1'b0;
		rtsc <= 1'b0;
		dtrc <= 1'b0;
		txs <= 1'b0;
		mdm <= 4'h0;
		lb <= 1'b1;
		repeat (3) @(negedge clk);
		chk({o_tx_pin, o_rx_serial, o_rts_n, o_dtr_n, o_modem_n}, 9'h0BF);
		@(posedge clk);
		lb <= 1'b0;
		repeat (3) @(negedge clk);
		chk({o_tx_pin, o_rx_serial, o_rts_n, o_dtr_n, o_modem_n}, 9'h040);
		// infrared pulse widths: 1.0, 1.1, 1.1 without unlock
		for (int i = 0; i < 3; i++) begin
			rst_dut();
			@(posedge clk);
			{rtsc, dtrc, txs, mdm, ire} <= 8'hFF;
			{ir11, unl} <= (i == 0) ? 2'h1 : ((i == 1) ? 2'h3 : 2'h2);
			repeat (4) @(posedge clk);
			txs <= 1'b0;
			k = 0;
			repeat (16) begin
				@(negedge clk);
				if (o_tx_pin === 1'b1) k++;
				chk(o_rx_serial, 1'b1);
			end
			chk(o_tx_pin, 1'b0);
			chk(9'(k), (i == 1) ? 9'h004 : 9'h003);
		end
		// infrared receive: light pulse decodes to a zero bit
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		k = 0;
		while (o_rx_serial !== 1'b0 && k < 6) begin
			@(negedge clk);
			k++;
		end
		chk(o_rx_serial, 1'b0);
		if (o_rx_serial !== 1'b0) summarize();
		// sleep entry, each of the five cnd conditions spoiled in turn
		rst_dut();
		@(posedge clk);
		{ire, ir11} <= 2'h0;
		sen <= 1'b1;
		cnd <= 5'h1E;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			cnd <= 5'h1F ^ (5'h01 << i);
			hold(1'b0, 3);
		end
		@(posedge clk);
		cnd <= 5'h1F;
		wait_sl(1'b1, 4);
		chk({o_osc_run, o_bus_isolated}, 9'h000);
		@(posedge clk);
		pls <= 4'h4;
		cnd <= 5'h1E;
		@(posedge clk);
		pls <= 4'h0;
		wait_sl(1'b0, 4);
		chk({o_osc_run, o_wake_int}, 9'h002);
		hold(1'b0, 4);
		@(posedge clk);
		cnd <= 5'h1F;
		wait_sl(1'b1, 4);
		@(posedge clk);
		wie <= 1'b1;
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		wait_sl(1'b0, 8);
		chk(o_wake_int, 1'b1);
		wait_sl(1'b1, 24);
		pulse(4'h8);
		@(negedge clk);
		chk(o_wake_int, 1'b0);
		// bus isolation while asleep
		@(posedge clk);
		iso <= 1'b1;
		sen <= 1'b0;
		wait_sl(1'b0, 4);
		@(posedge clk);
		sen <= 1'b1;
		wait_sl(1'b1, 4);
		chk(o_bus_isolated, 1'b1);
		pulse(4'h4);
		hold(1'b1, 4);
		@(posedge clk);
		mdm <= 4'h7;
		wait_sl(1'b0, 6);
		wait_sl(1'b1, 6);
		@(posedge clk);
		lb <= 1'b1;
		mdm <= 4'hF;
		txs <= 1'b1;
		hold(1'b1, 6);
		@(posedge clk);
		sen <= 1'b0;
		lb <= 1'b0;
		wait_sl(1'b0, 4);
		hold(1'b0, 3);
		summarize();
	end
endmodule : tb_top
